/* File: design/multicast_hash_and_wake_event_regs.v */
// apb register bank: group-address hash table words and power event control/status
// assumes a single 50 MHz clk_sys; receive filter and wake source are on the same clock
//
// The APB slave port was left to the implementer.
`include "group_hash_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RQ1] set table bit accepts the frame
// [RQ2] clear table bit drops multicast frame
// [RQ3] accept-all settings bypass the hash table
// [RQ4] four 16-bit table words, reset zero
// [RQ5] wake event sets flag bit 15
// [RQ6] flag and enable assert wake pin low
// [RQ7] flag cleared by power-up or write one
// [RQ8] flag survives hardware and software reset
// [RQ9] clearing flag releases the wake pin
// [RQ10] bit 8 enable gates the wake pin
// [RQ11] enable cleared only by power-up reset
// [RQ12] index is six top crc bits
// [RQ13] top two bits pick word, rest bit
// [RQ14] crc is the ethernet frame check
// [RQ15] reserved bits read zero, writes ignored
module multicast_hash_and_wake_event_regs #(
	parameter ADDR_BITS = 48
) (
	// clock and resets
	input wire clk_sys,
	input wire sys_rst,
	input wire powerUpRst,
	input wire softRst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [9:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// receive filter
	input wire frameValid,
	input wire frameMulticast,
	input wire [ADDR_BITS-1:0] destAddr,
	output reg filterDone,
	output reg frameAccept,
	// wake source and pin
	input wire wakeEventIn,
	output reg wake_event_output_n,
	// interrupt
	output reg irq
);
	////////////////////////////////////////////////////////////////////////////////
	// register file
	// flat table: bit index equals the six-bit hash index
	wire [63:0] hashTable;
	reg [1:0] receive_control_reg;
	reg [`IRQ_BITS-1:0] irqStatus;
	reg [`IRQ_BITS-1:0] irqMask;
	wire wake_event_flag;
	wire wake_output_enable;
	wire [7:0] regIdx;
	wire access;
	wire wrAccess;
	wire aligned;
	reg hit;
	reg [31:0] next_rdata;

	assign regIdx = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'b00);
	// one wait state: ready in the cycle after the first access cycle
	assign access = psel && penable && !pready;
	assign wrAccess = access && pwrite && hit;

	always @* begin
		hit = aligned;
		next_rdata = 32'h00000000;
		if (regIdx == `IDX_HASH_WORD0)
			next_rdata = {16'h0000, hashTable[15:0]};
		else if (regIdx == `IDX_HASH_WORD1)
			next_rdata = {16'h0000, hashTable[31:16]}; // [RQ4]
		else if (regIdx == `IDX_HASH_WORD2)
			next_rdata = {16'h0000, hashTable[47:32]}; // [RQ4]
		else if (regIdx == `IDX_HASH_WORD3)
			next_rdata = {16'h0000, hashTable[63:48]}; // [RQ4]
		else if (regIdx == `IDX_POWER_EVENT)
			next_rdata = {16'h0000, wake_event_flag, 6'h00, wake_output_enable, 8'h00}; // [RQ15]
		else if (regIdx == `IDX_IRQ_STATUS)
			next_rdata = {30'h0, irqStatus};
		else if (regIdx == `IDX_IRQ_MASK)
			next_rdata = {30'h0, irqMask};
		else if (regIdx == `IDX_RX_CONTROL)
			next_rdata = {30'h0, receive_control_reg};
		else
			hit = 1'b0;
	end

	// apb answer
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= access;
			pslverr <= access && !hit;
			prdata <= (access && !pwrite && hit) ? next_rdata : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// hash table words and receive control
	wire [3:0] hashWr;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : gHash
			wire [7:0] myIdx;
			reg [15:0] word;
			assign myIdx = (gi == 0) ? `IDX_HASH_WORD0 : (gi == 1) ? `IDX_HASH_WORD1 :
				(gi == 2) ? `IDX_HASH_WORD2 : `IDX_HASH_WORD3;
			assign hashWr[gi] = wrAccess && (regIdx == myIdx);
			// one driver per word; the flat vector is only wired together
			assign hashTable[gi*16 +: 16] = word;
			always @(posedge clk_sys) begin
				if (sys_rst || softRst)
					word <= `RST_HASH_WORD; // [RQ4]
				else if (hashWr[gi])
					word <= pwdata[15:0]; // [RQ4]
			end
		end
	endgenerate

	always @(posedge clk_sys) begin
		if (sys_rst || softRst)
			receive_control_reg <= `RST_RX_CONTROL;
		else if (wrAccess && regIdx == `IDX_RX_CONTROL)
			receive_control_reg <= pwdata[1:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// wake flag and enable, insensitive to sys_rst
	wire pmWrite;
	assign pmWrite = wrAccess && (regIdx == `IDX_POWER_EVENT);

	wake_event_keeper uKeeper (
		.clk_sys(clk_sys),
		.powerUpRst(powerUpRst),
		.softRst(softRst),
		.wakeEvent(wakeEventIn),
		.clearFlag(pmWrite && pwdata[`BIT_WAKE_FLAG]),
		.writeEnable(pmWrite),
		.enableValue(pwdata[`BIT_WAKE_ENABLE]),
		.wakeFlag(wake_event_flag),
		.wakeEnable(wake_output_enable)
	);

	// pin follows the flag; released when the flag clears or enable is low
	always @(posedge clk_sys) begin
		if (powerUpRst)
			wake_event_output_n <= 1'b1;
		else
			wake_event_output_n <= !(wake_event_flag && wake_output_enable); // [RQ6] [RQ9] [RQ10]
	end

	////////////////////////////////////////////////////////////////////////////////
	// receive filter
	wire crcDone;
	wire [`HASH_IDX_BITS-1:0] hashIndex;
	reg pendMulticast;
	reg pendBusy;
	wire crcStart;
	assign crcStart = frameValid && !pendBusy;

	dest_addr_crc #(
		.ADDR_BITS(ADDR_BITS)
	) uCrc (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.start(crcStart),
		.addr(destAddr),
		.done(crcDone),
		.hashIndex(hashIndex)
	);

	wire [15:0] selWord;
	wire tableBit;
	wire acceptAny;
	wire dropEvent;
	assign selWord = hashTable[{hashIndex[5:4], 4'h0} +: 16]; // [RQ13]
	assign tableBit = selWord[hashIndex[3:0]]; // [RQ13]
	assign acceptAny = receive_control_reg[`BIT_ACCEPT_ALL] || receive_control_reg[`BIT_ACCEPT_GROUP];
	assign dropEvent = crcDone && pendMulticast && !acceptAny && !tableBit;

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			pendMulticast <= 1'b0;
			pendBusy <= 1'b0;
			filterDone <= 1'b0;
			frameAccept <= 1'b0;
		end else begin
			filterDone <= crcDone;
			if (crcStart) begin
				pendMulticast <= frameMulticast;
				pendBusy <= 1'b1;
			end
			if (crcDone) begin
				pendBusy <= 1'b0;
				if (!pendMulticast)
					frameAccept <= 1'b1;
				else if (acceptAny)
					frameAccept <= 1'b1; // [RQ3]
				else
					frameAccept <= tableBit; // [RQ1] [RQ2]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status, mask and line
	wire [`IRQ_BITS-1:0] irqSet;
	wire [`IRQ_BITS-1:0] irqClr;
	assign irqSet = {dropEvent, wakeEventIn};
	assign irqClr = (wrAccess && regIdx == `IDX_IRQ_STATUS) ? pwdata[`IRQ_BITS-1:0] : `RST_IRQ;

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			irqStatus <= `RST_IRQ;
			irqMask <= `RST_IRQ;
			irq <= 1'b0;
		end else begin
			// set wins over a simultaneous clear
			irqStatus <= (irqStatus & ~irqClr) | irqSet;
			if (wrAccess && regIdx == `IDX_IRQ_MASK)
				irqMask <= pwdata[`IRQ_BITS-1:0];
			irq <= |(irqStatus & irqMask);
		end
	end
endmodule // multicast_hash_and_wake_event_regs

/* File: common/group_hash_map.vh */
// register offsets, field positions, reset values and timing for the hash/wake bank
// assumes byte addressing on a 32-bit bus; included by bare name
`ifndef GROUP_HASH_MAP_VH
`define GROUP_HASH_MAP_VH
// offsets are word indices; byte address is four times the index
`define IDX_HASH_WORD1 8'h02
`define IDX_HASH_WORD2 8'h04
`define IDX_HASH_WORD3 8'h06
`define IDX_POWER_EVENT 8'h08
`define IDX_IRQ_STATUS 8'h10
`define IDX_IRQ_MASK 8'h11
`define IDX_RX_CONTROL 8'h12
`define IDX_HASH_WORD0 8'h13
// power event control/status fields
`define BIT_WAKE_FLAG 15
`define BIT_WAKE_ENABLE 8
// receive control fields
`define BIT_ACCEPT_ALL 0
`define BIT_ACCEPT_GROUP 1
// interrupt status fields
`define BIT_IRQ_WAKE 0
`define BIT_IRQ_DROP 1
`define IRQ_BITS 2
// reset values
`define RST_HASH_WORD 16'h0000
`define RST_RX_CONTROL 2'h0
`define RST_IRQ 2'h0
// hash geometry
`define HASH_IDX_BITS 6
`define CRC_INIT 32'hffffffff
`define CRC_POLY 32'hedb88320
// number of clk_sys cycles the crc engine takes for 48 address bits
`define CRC_CYCLES 6'd48
`endif

/* File: design/dest_addr_crc.v */
// bit-serial crc over a 48-bit destination address, first octet first, lsb of each octet first
// assumes start is a one-cycle pulse on clk_sys; addr held by caller is captured at start
`include "group_hash_map.vh"
module dest_addr_crc #(
	parameter ADDR_BITS = 48
) (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// request
	input wire start,
	input wire [ADDR_BITS-1:0] addr,
	// answer
	output reg done,
	output reg [`HASH_IDX_BITS-1:0] hashIndex
);
	reg [31:0] crc;
	reg [ADDR_BITS-1:0] shiftAddr;
	reg [5:0] count;
	reg busy;
	wire feed;
	wire [31:0] next_crc;
	// addr[47:40] is the first octet on the wire; its lsb goes first
	assign feed = crc[0] ^ shiftAddr[ADDR_BITS-8];
	assign next_crc = feed ? ((crc >> 1) ^ `CRC_POLY) : (crc >> 1);
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			crc <= `CRC_INIT;
			shiftAddr <= {ADDR_BITS{1'b0}};
			count <= 6'd0;
			busy <= 1'b0;
			done <= 1'b0;
			hashIndex <= {`HASH_IDX_BITS{1'b0}};
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				crc <= `CRC_INIT;
				shiftAddr <= addr;
				count <= 6'd0;
				busy <= 1'b1;
			end else if (busy) begin
				crc <= next_crc; // [RQ14]
				// walk octet bits lsb first, then move to next octet
				if (count[2:0] == 3'd7)
					shiftAddr <= {shiftAddr[ADDR_BITS-9:0], 8'h00};
				else
					shiftAddr <= {1'b0, shiftAddr[ADDR_BITS-1:ADDR_BITS-7], shiftAddr[ADDR_BITS-9:0]};
				count <= count + 6'd1;
				if (count == `CRC_CYCLES - 6'd1) begin
					busy <= 1'b0;
					done <= 1'b1;
					// six most significant crc bits of the final, lsb-first register
					hashIndex <= {next_crc[26], next_crc[27], next_crc[28],
						next_crc[29], next_crc[30], next_crc[31]}; // [RQ12]
				end
			end
		end
	end
endmodule // dest_addr_crc

/* File: design/wake_event_keeper.v */
// sticky wake-event flag and wake enable with power-up versus soft reset behaviour
// assumes power-up reset is a synchronous pulse on clk_sys, separate from sys_rst
`include "group_hash_map.vh"
module wake_event_keeper (
	// clock and resets
	input wire clk_sys,
	input wire powerUpRst,
	input wire softRst,
	// inputs
	input wire wakeEvent,
	input wire clearFlag,
	input wire writeEnable,
	input wire enableValue,
	// state
	output reg wakeFlag,
	output reg wakeEnable
);
	// sys_rst is deliberately absent: the flag survives hardware and soft reset
	always @(posedge clk_sys) begin
		if (powerUpRst) begin
			wakeFlag <= 1'b0; // [RQ7]
			wakeEnable <= 1'b0; // [RQ11]
		end else begin
			if (wakeEvent)
				wakeFlag <= 1'b1; // [RQ5]
			else if (clearFlag)
				wakeFlag <= 1'b0; // [RQ7] [RQ8]
			// enable keeps its value through soft reset
			if (writeEnable && !softRst)
				wakeEnable <= enableValue; // [RQ11]
		end
	end
endmodule // wake_event_keeper

/* File: verification/multicast_hash_and_wake_event_regs_assertions.sv */
// port-level checker for the hash table and wake event bank
// assumes it is bound into the bank, one clock domain
module bank_checker (
	// clock and resets
	input wire clk_sys,
	input wire sys_rst,
	input wire powerUpRst,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [9:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// filter and wake
	input wire frameValid,
	input wire filterDone,
	input wire wake_event_output_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire take = psel && penable && !pready;
	wire mapped = paddr inside {10'h008, 10'h010, 10'h018, 10'h020, 10'h040, 10'h044, 10'h048, 10'h04c};
	////////////////////////////////////////////////////////////////////////////////
	sequence s_release;
		take && pwrite && paddr == 10'h020 && (pwdata[15] || !pwdata[8]);
	endsequence
	sequence s_read;
		pready && !pwrite;
	endsequence
	property p_answer; take |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_refuse; take |=> pslverr == !$past(mapped); endproperty
	property p_reserved; s_read ##0 paddr == 10'h020 |-> (prdata & 32'hffff7eff) == 32'h0; endproperty
	property p_upper; s_read |-> prdata[31:16] == 16'h0; endproperty
	// taken at edge t, crc done at t+48, filterDone launched at t+49, seen at t+50
	property p_latency; filterDone |-> $past(frameValid, 50); endproperty
	property p_done; filterDone |=> !filterDone; endproperty
	property p_release; s_release |-> ##2 wake_event_output_n; endproperty
	property p_powerup; powerUpRst |=> wake_event_output_n; endproperty
	a_answer: assert property (p_answer) else $error("access not answered");
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	a_refuse: assert property (p_refuse) else $error("wrong error response");
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
	a_upper: assert property (p_upper) else $error("upper half not zero");
	a_latency: assert property (p_latency) else $error("filter answer late or early");
	a_done: assert property (p_done) else $error("filter done held");
	a_release: assert property (p_release) else $error("wake pin not released");
	a_powerup: assert property (p_powerup) else $error("wake pin kept after power-up");
endmodule // bank_checker

bind multicast_hash_and_wake_event_regs bank_checker checker_i (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .powerUpRst(powerUpRst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.frameValid(frameValid), .filterDone(filterDone), .wake_event_output_n(wake_event_output_n)
);

/* File: verification/rx_side_model.sv */
// far side: receive path handing over addresses, and a wake source
// assumes the bench calls its tasks, one frame at a time
module rx_side_model (
	// clock
	input wire clk_sys,
	// towards the bank
	output logic frameValid,
	output logic frameMulticast,
	output logic [47:0] destAddr,
	output logic wakeEventIn
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		frameValid = 1'b0;
		frameMulticast = 1'b0;
		destAddr = 48'h0;
		wakeEventIn = 1'b0;
	end
	task automatic sendFrame(input logic mc, input logic [47:0] a);
		@(posedge clk_sys);
		frameValid <= 1'b1;
		frameMulticast <= mc;
		destAddr <= a;
		@(posedge clk_sys);
		// no longer held: show the inverse, never a stale copy
		frameValid <= 1'b0;
		frameMulticast <= ~mc;
		destAddr <= ~a;
	endtask
	task automatic pulseWake();
		@(posedge clk_sys);
		wakeEventIn <= 1'b1;
		@(posedge clk_sys);
		wakeEventIn <= 1'b0;
	endtask
endmodule // rx_side_model

/* File: verification/tb_top.sv */
// self-checking bench for the hash table and wake event bank
// assumes one-wait-state apb answers and a 49-cycle filter answer
`include "group_hash_map.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic powerUpRst = 1'b1;
	logic softRst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, filterDone, frameAccept, wake_event_output_n, irq;
	wire frameValid, frameMulticast, wakeEventIn;
	wire [47:0] destAddr;
	int num_errors = 0;
	int comparisons = 0;
	logic [32:0] apbNotes[$];
	logic filterNotes[$];
	logic [31:0] seed = 32'h0001089c;
	logic [9:0] tableAddr[4] = '{10'h04c, 10'h008, 10'h010, 10'h018};
	always #10 clk_sys = ~clk_sys;
	multicast_hash_and_wake_event_regs #(.ADDR_BITS(48)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .powerUpRst(powerUpRst), .softRst(softRst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frameValid(frameValid), .frameMulticast(frameMulticast), .destAddr(destAddr),
		.filterDone(filterDone), .frameAccept(frameAccept),
		.wakeEventIn(wakeEventIn), .wake_event_output_n(wake_event_output_n), .irq(irq)
	);
	rx_side_model src (
		.clk_sys(clk_sys), .frameValid(frameValid), .frameMulticast(frameMulticast),
		.destAddr(destAddr), .wakeEventIn(wakeEventIn)
	);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// first octet first, lsb of each octet first
	function automatic logic [5:0] hashOf(input logic [47:0] a);
		logic [31:0] c;
		c = `CRC_INIT;
		for (int i = 0; i < 48; i++)
			c = (c >> 1) ^ ((c[0] ^ a[40 - 8 * (i / 8) + i % 8]) ? `CRC_POLY : 32'h0);
		return {c[26], c[27], c[28], c[29], c[30], c[31]};
	endfunction
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic [9:0] a, input logic w, input logic [31:0] d, input logic [32:0] exp);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		apbNotes.push_back(exp);
		@(posedge clk_sys);
		penable <= 1'b1;
		// wait until pready rises; the watchdog ends it if pready never does
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 33'h0);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0, {1'b0, e});
	endtask
	task automatic frame(input logic mc, input logic [47:0] a, input logic e);
		filterNotes.push_back(e);
		src.sendFrame(mc, a);
		repeat (52) @(posedge clk_sys);
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		if (pready === 1'b1 && psel === 1'b1 && apbNotes.size() > 0)
			check({pslverr, prdata}, apbNotes.pop_front());
		if (filterDone === 1'b1 && filterNotes.size() > 0)
			check(frameAccept, filterNotes.pop_front());
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		num_errors++;
		report_and_stop();
	end
	initial begin
		logic [47:0] da;
		logic [5:0] idx;
		logic [31:0] v;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		powerUpRst <= 1'b0;
		foreach (tableAddr[k]) rd(tableAddr[k], 32'h0);
		rd(10'h020, 32'h0);
		for (int k = 1; k < 4; k++) begin
			v = rnd();
			wr(tableAddr[k], v);
			rd(tableAddr[k], {16'h0, v[15:0]});
		end
		apb(10'h00c, 1'b1, 32'h1, {1'b1, 32'h0});
		apb(10'h3fc, 1'b0, 32'h0, {1'b1, 32'h0});
		foreach (tableAddr[k]) wr(tableAddr[k], 32'h0);
		v = rnd();
		da = {v[15:0], rnd()};
		da[40] = 1'b1;
		idx = hashOf(da);
		wr(tableAddr[idx[5:4]], 32'h1 << idx[3:0]);
		frame(1'b1, da, 1'b1);
		wr(tableAddr[idx[5:4]], ~(32'h1 << idx[3:0]));
		frame(1'b1, da, 1'b0);
		rd(10'h040, 32'h2);
		frame(1'b0, da, 1'b1);
		for (int m = 1; m < 3; m++) begin
			wr(10'h048, m);
			frame(1'b1, da, 1'b1);
		end
		wr(10'h048, 32'h0);
		wr(10'h040, 32'h3);
		src.pulseWake();
		rd(10'h020, 32'h8000);
		check(wake_event_output_n, 1'b1);
		rd(10'h040, 32'h1);
		check(irq, 1'b0);
		wr(10'h044, 32'h1);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b1);
		wr(10'h040, 32'h1);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b0);
		wr(10'h020, 32'h0100);
		rd(10'h020, 32'h8100);
		check(wake_event_output_n, 1'b0);
		@(posedge clk_sys);
		softRst <= 1'b1;
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		softRst <= 1'b0;
		sys_rst <= 1'b0;
		rd(10'h020, 32'h8100);
		rd(tableAddr[idx[5:4]], 32'h0);
		wr(10'h020, 32'hffff);
		rd(10'h020, 32'h0100);
		check(wake_event_output_n, 1'b1);
		src.pulseWake();
		repeat (2) @(posedge clk_sys);
		check(wake_event_output_n, 1'b0);
		@(posedge clk_sys);
		powerUpRst <= 1'b1;
		@(posedge clk_sys);
		powerUpRst <= 1'b0;
		rd(10'h020, 32'h0);
		check(wake_event_output_n, 1'b1);
		report_and_stop();
	end
endmodule // tb_top
